// ### tmr_pkg.sv
// Purpose: Shared constants and types for the dual timer/counter pair.
// Assumes: One system clock, the machine cycle is derived inside the block.
// Notes:   Offsets, reset values, field positions and cycle counts live here.
package tmr_pkg;

  // Special function register address of the mode register and its reset value.
  localparam logic [7:0] TMR_MODE_ADDR  = 8'h89;
  localparam logic [7:0] TMR_MODE_RESET = 8'h00;

  // Field positions inside the mode register.
  localparam int TMR_T0_MODE_LSB = 0;
  localparam int TMR_T0_SRC_BIT  = 2;
  localparam int TMR_T0_GATE_BIT = 3;
  localparam int TMR_T1_MODE_LSB = 4;

  // CPU clocks per machine cycle.
  localparam int         TMR_MC_CLOCKS = 6;
  localparam logic [2:0] TMR_MC_LAST   = 3'(TMR_MC_CLOCKS - 1);

  // Selector codes for the count byte write port.
  localparam logic [1:0] TMR_SEL_LO0 = 2'h0;
  localparam logic [1:0] TMR_SEL_HI0 = 2'h1;
  localparam logic [1:0] TMR_SEL_LO1 = 2'h2;
  localparam logic [1:0] TMR_SEL_HI1 = 2'h3;

  // Level of the toggle output before the first overflow.
  localparam logic TMR_TOGGLE_RESET = 1'b1;

  // Operating modes, shared by both timers.
  typedef enum logic [1:0] {
    TMR_MODE_13    = 2'b00,
    TMR_MODE_16    = 2'b01,
    TMR_MODE_RLD   = 2'b10,
    TMR_MODE_SPLIT = 2'b11
  } tmr_mode_t;

endpackage

// ### tmr_dual_timer.sv
// Purpose: Two up-counting timer/counters configured by one mode register.
// Assumes: Count pin, gating pin and run bits are synchronous to sys_clk_in.
// Notes:   Count bytes are written through a small byte port with its own selector.
`timescale 1ns/1ps
`default_nettype none
module tmr_dual_timer (
  input  wire logic       sys_clk_in,             // CPU clock, 100 MHz.
  input  wire logic       rst_n_in,               // Asynchronous reset, active low.
  input  wire logic [7:0] sfr_addr_in,            // Special function register address.
  input  wire logic       sfr_wr_in,              // Register write strobe.
  input  wire logic [7:0] sfr_wdata_in,           // Register write data.
  output logic      [7:0] sfr_rdata_out,          // Register read data, one cycle late.
  input  wire logic       cnt_wr_in,              // Count byte write strobe.
  input  wire logic [1:0] cnt_sel_in,             // Count byte selector.
  input  wire logic [7:0] cnt_wdata_in,           // Count byte write data.
  input  wire logic       timer_zero_run_in,      // Timer 0 run bit.
  input  wire logic       timer_one_run_in,       // Timer 1 run bit.
  input  wire logic       flag_zero_clr_in,       // Clears timer 0 overflow flag.
  input  wire logic       flag_one_clr_in,        // Clears timer 1 overflow flag.
  input  wire logic       gating_pin_in,          // External gating pin level.
  input  wire logic       count_input_pin_in,     // Count pin level.
  input  wire logic       overflow_toggle_enable_in, // Drive toggle onto the count pin.
  output logic            count_pin_out,          // Toggle level for the count pin.
  output logic            count_pin_oe_n_out,     // Low while the pin is driven.
  output logic      [7:0] count_low_byte0_out,    // Timer 0 low byte.
  output logic      [7:0] count_high_byte0_out,   // Timer 0 high byte.
  output logic      [7:0] count_low_byte1_out,    // Timer 1 low byte.
  output logic      [7:0] count_high_byte1_out,   // Timer 1 high byte.
  output logic            overflow_flag0_out,     // Timer 0 overflow flag.
  output logic            overflow_flag1_out      // Timer 1 overflow flag.
);
  import tmr_pkg::*;

  logic [2:0] mc_cnt_reg, mc_cnt_next;
  logic       tick;
  logic [7:0] mode_reg, mode_next;
  logic [7:0] rdata_reg, rdata_next;
  logic       samp_reg, samp_next;
  logic       edge_pend_reg, edge_pend_next;
  logic [7:0] lo0_reg, lo0_next, hi0_reg, hi0_next;
  logic [7:0] lo1_reg, lo1_next, hi1_reg, hi1_next;
  logic       flag0_reg, flag0_next, flag1_reg, flag1_next;
  logic       tog_reg, tog_next;
  tmr_mode_t  t0_mode, t1_mode;
  logic       t0_en, t0_inc, t1_inc, hi0_inc;
  logic       ovf0, ovf1, ovf_hi0;
  logic [16:0] t0_res, t1_res;
  logic [8:0]  lo0_sum, hi0_sum;

  // Advance one timer by one step in the shared modes; bit 16 marks rollover.
  function automatic logic [16:0] tmr_step(input tmr_mode_t m, input logic [7:0] lo,
                                           input logic [7:0] hi, input logic inc);
    logic [16:0] r;
    r = {1'b0, hi, lo};
    if (inc) begin
      case (m)
        TMR_MODE_13: begin
          r[4:0] = lo[4:0] + 5'h01;
          if (lo[4:0] == 5'h1f) begin
            r[16:8] = {1'b0, hi} + 9'h001;
          end
        end
        TMR_MODE_16: r = {1'b0, hi, lo} + 17'h00001;
        TMR_MODE_RLD: begin
          if (lo == 8'hff) begin
            r = {1'b1, hi, hi};
          end else begin
            r[7:0] = lo + 8'h01;
          end
        end
        default: r = {1'b0, hi, lo};
      endcase
    end
    return r;
  endfunction

  assign t0_mode = tmr_mode_t'(mode_reg[TMR_T0_MODE_LSB +: 2]);
  assign t1_mode = tmr_mode_t'(mode_reg[TMR_T1_MODE_LSB +: 2]);

  assign tick = (mc_cnt_reg == TMR_MC_LAST);

  // Enables and increments; a detected fall counts on the clock after its sampling tick.
  always_comb begin
    t0_en   = timer_zero_run_in & (~mode_reg[TMR_T0_GATE_BIT] | gating_pin_in);
    t0_inc  = t0_en & (mode_reg[TMR_T0_SRC_BIT] ? edge_pend_reg : tick);
    hi0_inc = tick & timer_one_run_in & (t0_mode == TMR_MODE_SPLIT);
    t1_inc  = tick & timer_one_run_in & (t1_mode != TMR_MODE_SPLIT);
  end

  // Next state of every register; software byte writes override counting.
  always_comb begin
    mc_cnt_next    = tick ? 3'h0 : mc_cnt_reg + 3'h1;
    mode_next      = mode_reg;
    rdata_next     = (sfr_addr_in == TMR_MODE_ADDR) ? mode_reg : 8'h00;
    samp_next      = samp_reg;
    // The pending edge lasts one clock, so each fall is counted exactly once.
    edge_pend_next = 1'b0;
    if (tick) begin
      samp_next      = count_input_pin_in;
      edge_pend_next = samp_reg & ~count_input_pin_in;
    end
    if (sfr_wr_in && sfr_addr_in == TMR_MODE_ADDR) begin
      mode_next = sfr_wdata_in;
    end
    t0_res  = tmr_step(t0_mode, lo0_reg, hi0_reg, t0_inc);
    t1_res  = tmr_step(t1_mode, lo1_reg, hi1_reg, t1_inc);
    lo0_sum = {1'b0, lo0_reg} + {8'h00, t0_inc};
    hi0_sum = {1'b0, hi0_reg} + {8'h00, hi0_inc};
    if (t0_mode == TMR_MODE_SPLIT) begin
      lo0_next = lo0_sum[7:0];
      hi0_next = hi0_sum[7:0];
      ovf0     = lo0_sum[8];
      ovf_hi0  = hi0_sum[8];
    end else begin
      lo0_next = t0_res[7:0];
      hi0_next = t0_res[15:8];
      ovf0     = t0_res[16];
      ovf_hi0  = 1'b0;
    end
    lo1_next = t1_res[7:0];
    hi1_next = t1_res[15:8];
    ovf1     = t1_res[16] & (t0_mode != TMR_MODE_SPLIT);
    if (cnt_wr_in) begin
      case (cnt_sel_in)
        TMR_SEL_LO0: lo0_next = cnt_wdata_in;
        TMR_SEL_HI0: hi0_next = cnt_wdata_in;
        TMR_SEL_LO1: lo1_next = cnt_wdata_in;
        TMR_SEL_HI1: hi1_next = cnt_wdata_in;
        default:     lo0_next = lo0_next;
      endcase
    end
    flag0_next = ovf0 | (flag0_reg & ~flag_zero_clr_in);
    flag1_next = ovf1 | ovf_hi0 | (flag1_reg & ~flag_one_clr_in);
    tog_next   = (ovf0 & overflow_toggle_enable_in) ? ~tog_reg : tog_reg;
    if (!overflow_toggle_enable_in) begin
      tog_next = TMR_TOGGLE_RESET;
    end
  end

  // State registers.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mc_cnt_reg    <= 3'h0;
      mode_reg      <= TMR_MODE_RESET;
      rdata_reg     <= 8'h00;
      samp_reg      <= 1'b0;
      edge_pend_reg <= 1'b0;
      lo0_reg       <= 8'h00;
      hi0_reg       <= 8'h00;
      lo1_reg       <= 8'h00;
      hi1_reg       <= 8'h00;
      flag0_reg     <= 1'b0;
      flag1_reg     <= 1'b0;
      tog_reg       <= TMR_TOGGLE_RESET;
    end else begin
      mc_cnt_reg    <= mc_cnt_next;
      mode_reg      <= mode_next;
      rdata_reg     <= rdata_next;
      samp_reg      <= samp_next;
      edge_pend_reg <= edge_pend_next;
      lo0_reg       <= lo0_next;
      hi0_reg       <= hi0_next;
      lo1_reg       <= lo1_next;
      hi1_reg       <= hi1_next;
      flag0_reg     <= flag0_next;
      flag1_reg     <= flag1_next;
      tog_reg       <= tog_next;
    end
  end

  // Outputs except the pin enable come straight from registers.
  assign sfr_rdata_out        = rdata_reg;
  assign count_low_byte0_out  = lo0_reg;
  assign count_high_byte0_out = hi0_reg;
  assign count_low_byte1_out  = lo1_reg;
  assign count_high_byte1_out = hi1_reg;
  assign overflow_flag0_out   = flag0_reg;
  assign overflow_flag1_out   = flag1_reg;
  assign count_pin_out        = tog_reg;
  // The pin is only driven in toggle mode; counting from it then sees our own level.
  assign count_pin_oe_n_out   = ~overflow_toggle_enable_in;

  // Checks on the block's own behaviour.
  tick_period_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    tick |=> !tick [*5] ##1 tick) else $error("Machine cycle is not six clocks.");

  edge_count_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (t0_en && mode_reg[TMR_T0_SRC_BIT] && edge_pend_reg && t0_mode == TMR_MODE_16
     && lo0_reg != 8'hff && !cnt_wr_in) |=> (lo0_reg == $past(lo0_reg) + 8'h01))
    else $error("Detected edge did not advance the count.");

  no_edge_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (mode_reg[TMR_T0_SRC_BIT] && !edge_pend_reg && t0_mode != TMR_MODE_SPLIT && !cnt_wr_in)
    |=> $stable(lo0_reg) && $stable(hi0_reg)) else $error("Count moved without an edge.");

  gate_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (mode_reg[TMR_T0_GATE_BIT] && !gating_pin_in && t0_mode != TMR_MODE_SPLIT && !cnt_wr_in)
    |=> $stable({hi0_reg, lo0_reg})) else $error("Gated timer 0 counted.");

  reload_val_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (t0_mode == TMR_MODE_RLD && t0_inc && lo0_reg == 8'hff && !cnt_wr_in)
    |=> lo0_reg == $past(hi0_reg) && overflow_flag0_out) else $error("Reload failed.");

  flag_set_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (ovf0 && flag_zero_clr_in) |=> overflow_flag0_out) else $error("Overflow flag lost.");

  t1_stop_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (t1_mode == TMR_MODE_SPLIT && !cnt_wr_in) |=> $stable({hi1_reg, lo1_reg}))
    else $error("Timer 1 counted in mode 3.");

  toggle_pin_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (ovf0 && overflow_toggle_enable_in) |=> count_pin_out != $past(count_pin_out))
    else $error("Pin did not toggle on overflow.");

  split_hi_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (t0_mode == TMR_MODE_SPLIT && tick && timer_one_run_in && hi0_reg == 8'hff && !cnt_wr_in)
    |=> hi0_reg == 8'h00 && overflow_flag1_out) else $error("Split high byte wrong.");

endmodule // tmr_dual_timer
`default_nettype wire

// ### tmr_pin_model.sv
// Purpose: Count pin source that stands outside the timer pair.
// Assumes: Pins change just after the rising clock edge.
// Notes:   The level stands still while run_in is low.
`timescale 1ns/1ps
`default_nettype none
module tmr_pin_model (
  input  wire logic sys_clk_in, // CPU clock.
  input  wire logic run_in,     // Square wave runs while high.
  output logic      pin_out     // Count pin level.
);
  logic [2:0] cnt_reg;

  // Idle high, so stopping on a high level never adds an edge.
  initial begin
    pin_out = 1'b1;
    cnt_reg = 3'h0;
  end

  // one machine cycle
  // Each level lasts six clocks, the shortest that the sampler is sure to see.
  always @(posedge sys_clk_in) begin
    if (run_in) begin
      cnt_reg <= (cnt_reg == 3'h5) ? 3'h0 : cnt_reg + 3'h1;
      if (cnt_reg == 3'h5) pin_out <= #1 ~pin_out;
    end
  end
endmodule // tmr_pin_model
`default_nettype wire

// ### tb_dual_timer_counter_pair.sv
// Purpose: Self-checking bench for the dual timer/counter pair.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   Runs are whole multiples of six clocks, so tick phase never matters.
`timescale 1ns/1ps
`default_nettype none
module tb_dual_timer_counter_pair;
  import tmr_pkg::*;
  logic       clk, rst_n, wr, cwr, run0, run1, clr0, clr1, gate, tog, prun;
  logic       psrc, pout, poe_n, f0, f1, cin;
  logic [7:0] addr, wd, rd, cdat, lo0, hi0, lo1, hi1;
  logic [1:0] csel;
  int         n_fail, total_checks, cyc;

  // The shared pin carries the toggle level whenever the block drives it.
  assign cin = poe_n ? psrc : pout;

  tmr_pin_model tmr_pin_model_inst (.sys_clk_in(clk), .run_in(prun), .pin_out(psrc));

  tmr_dual_timer tmr_dual_timer_inst (
    .sys_clk_in(clk), .rst_n_in(rst_n), .sfr_addr_in(addr), .sfr_wr_in(wr),
    .sfr_wdata_in(wd), .sfr_rdata_out(rd), .cnt_wr_in(cwr), .cnt_sel_in(csel),
    .cnt_wdata_in(cdat), .timer_zero_run_in(run0), .timer_one_run_in(run1),
    .flag_zero_clr_in(clr0), .flag_one_clr_in(clr1), .gating_pin_in(gate),
    .count_input_pin_in(cin), .overflow_toggle_enable_in(tog), .count_pin_out(pout),
    .count_pin_oe_n_out(poe_n), .count_low_byte0_out(lo0), .count_high_byte0_out(hi0),
    .count_low_byte1_out(lo1), .count_high_byte1_out(hi1),
    .overflow_flag0_out(f0), .overflow_flag1_out(f1));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wmode(input logic [7:0] d);
    addr = TMR_MODE_ADDR;
    wr   = 1'b1;
    wd   = d;
    step(1);
    wr   = 1'b0;
  endtask

  // An idle edge follows each write, so back-to-back calls never pulse the strobe in zero time.
  task automatic wbyte(input logic [1:0] s, input logic [7:0] d);
    cwr  = 1'b1;
    csel = s;
    cdat = d;
    step(1);
    cwr  = 1'b0;
    step(1);
  endtask

  task automatic clr();
    clr0 = 1'b1;
    clr1 = 1'b1;
    step(1);
    clr0 = 1'b0;
    clr1 = 1'b0;
  endtask

  // Reset value, read back, and an unmapped address that must read zero.
  task automatic t_reg();
    addr = TMR_MODE_ADDR; step(2);
    chk("mode reset", TMR_MODE_RESET, rd);
    wmode(8'h3d); step(1);
    chk("mode readback", 8'h3d, rd);
    addr = 8'h88; step(2);
    chk("unmapped read", 8'h00, rd);
  endtask

  // Timer 0 runs k machine cycles from a preset; the mask hides undefined bits.
  task automatic t_tim(input logic [7:0] m, lo, hi, input int k,
                       input logic [7:0] el, eh, msk);
    wmode(m); wbyte(TMR_SEL_LO0, lo); wbyte(TMR_SEL_HI0, hi); clr();
    run0 = 1'b1; step(6 * k); run0 = 1'b0; step(2);
    chk("low byte 0", el, lo0 & msk);
    chk("high byte 0", eh, hi0);
    chk("flag 0", 8'h01, 8'(f0));
  endtask

  // Gating holds timer 0 while the pin is low.
  task automatic t_gate();
    wmode(8'h09); wbyte(TMR_SEL_LO0, 8'h00); gate = 1'b0; run0 = 1'b1; step(60);
    chk("gated low", 8'h00, lo0);
    gate = 1'b1; step(60); run0 = 1'b0; step(1);
    chk("gated high", 8'h0a, lo0);
  endtask

  // Counter function: a still pin gives nothing, ten falls give ten counts.
  task automatic t_cnt();
    wmode(8'h05); wbyte(TMR_SEL_LO0, 8'h00); run0 = 1'b1; step(60);
    chk("still pin", 8'h00, lo0);
    prun = 1'b1; step(120); prun = 1'b0; step(24); run0 = 1'b0; step(1);
    chk("edge count", 8'h0a, lo0);
  endtask

  // Timer 1 ignores gating and source bits, stops in mode 3, and lends its run bit.
  task automatic t_one();
    wmode(8'h1c);
    gate = 1'b0;
    wbyte(TMR_SEL_LO1, 8'h00);
    wbyte(TMR_SEL_HI1, 8'h42);
    run1 = 1'b1;
    step(30);
    run1 = 1'b0;
    chk("timer 1 ungated", 8'h05, lo1);
    chk("timer 1 high", 8'h42, hi1);
    wmode(8'h30);
    run1 = 1'b1;
    step(30);
    run1 = 1'b0;
    chk("timer 1 mode 3", 8'h05, lo1);
    wmode(8'h03);
    wbyte(TMR_SEL_HI0, 8'hff);
    wbyte(TMR_SEL_LO0, 8'h00);
    clr();
    run1 = 1'b1;
    step(12);
    run1 = 1'b0;
    step(2);
    chk("split high", 8'h01, hi0);
    chk("split low", 8'h00, lo0);
    chk("split flag 1", 8'h01, 8'(f1));
    chk("split flag 0", 8'h00, 8'(f0));
    // Timer 1 in mode 2 reloads from its high byte and flags its own overflow.
    wmode(8'h20);
    wbyte(TMR_SEL_LO1, 8'hfe);
    clr();
    run1 = 1'b1;
    step(18);
    run1 = 1'b0;
    step(2);
    chk("timer 1 reload low", 8'h43, lo1);
    chk("timer 1 reload high", 8'h42, hi1);
    chk("flag 1", 8'h01, 8'(f1));
  endtask

  // Clock and the hang limit.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      end_of_test();
    end
  end

  // Main sequence.
  initial begin
    {rst_n, wr, cwr, run0, run1, clr0, clr1, gate, tog, prun} = '0;
    {addr, wd, cdat, csel, n_fail, total_checks, cyc} = '0;
    step(12); rst_n = 1'b1;
    t_reg();
    t_tim(8'h01, 8'hfe, 8'hff, 3, 8'h01, 8'h00, 8'hff);
    t_tim(8'h00, 8'h1e, 8'hff, 2, 8'h00, 8'h00, 8'h1f);
    tog = 1'b1;
    t_tim(8'h02, 8'hfe, 8'h10, 3, 8'h11, 8'h10, 8'hff);
    chk("toggle level", 8'h00, 8'(pout));
    chk("pin driven", 8'h00, 8'(poe_n));
    tog = 1'b0; step(1);
    t_gate();
    t_cnt();
    t_one();
    end_of_test();
  end
endmodule // tb_dual_timer_counter_pair
`default_nettype wire
